//--- design/cfg_link_pkg.sv
// Constants for the single-wire configuration link
package cfg_link_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_NS = 5;
  localparam int TIMEOUT_MS = 28;
  localparam int POWERUP_MS = 25;
  localparam int TICK_MS = 10;
  localparam int IDLE_MS = 1000;
  localparam int MIN_BAUD = 4800;
  localparam int MAX_BAUD = 114000;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int POWERUP_CYC = POWERUP_MS * (CLK_HZ / 1000);
  localparam int TICK_CYC = TICK_MS * (CLK_HZ / 1000);
  localparam int IDLE_CYC = IDLE_MS * (CLK_HZ / 1000);
  // Longest bit allowed at the slowest rate, in clocks (with margin x2)
  localparam int MAX_BIT_CYC = 2 * (CLK_HZ / MIN_BAUD);
  localparam int MIN_BIT_CYC = CLK_HZ / MAX_BAUD / 2;
  localparam logic [7:0] INIT_BYTE = 8'h55;
  localparam int RW_BIT = 7;
  localparam int READ_GAP_BITS = 2;
  localparam int BIT_W = 20;
  localparam int TMR_W = 28;
  localparam int SLOTS = 4;
  localparam int BANKS = 7;
  localparam logic [2:0] RAM_SRC_RESET = 3'h0;
  localparam logic [7:0] OUT_CNT_RESET = 8'h00;
endpackage : cfg_link_pkg

//--- design/word_buffer.sv
// Two-entry valid/ready buffer for received words
`timescale 1ns/1ps
`default_nettype none
module word_buffer #(
  parameter int WIDTH = 16
) (
  input wire logic i_clk,               // Clock
  input wire logic i_rst,               // Sync reset, high
  input wire logic i_valid,             // Write valid
  output logic o_ready,                 // Room for a word
  input wire logic [WIDTH-1:0] i_data,  // Write data
  output logic o_valid,                 // Word available
  input wire logic i_ready,             // Reader takes word
  output logic [WIDTH-1:0] o_data       // Head word
);
  logic [WIDTH-1:0] mem_reg [2];
  logic rd_reg;
  logic wr_reg;
  logic [1:0] cnt_reg;
  logic push;
  logic pop;

  initial begin
    if (WIDTH < 1) $error("WIDTH must be positive");
  end

  assign o_ready = (cnt_reg != 2'h2);
  assign o_valid = (cnt_reg != 2'h0);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem_reg[rd_reg];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) wr_reg <= ~wr_reg;
      if (pop) rd_reg <= ~rd_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : word_buffer
`default_nettype wire

//--- design/power_sequencer.sv
// Power-up load, checksum gating and output-on countdown
`timescale 1ns/1ps
`default_nettype none
module power_sequencer #(
  parameter int POWERUP_CYC = cfg_link_pkg::POWERUP_CYC,
  parameter int TICK_CYC = cfg_link_pkg::TICK_CYC,
  parameter int IDLE_CYC = cfg_link_pkg::IDLE_CYC
) (
  input wire logic i_clk,                  // Clock
  input wire logic i_rst,                  // Sync reset, high
  input wire logic i_instant_output_bit,   // Skip power-up wait
  input wire logic [3:0] i_slot_valid,     // Pointer slots programmed
  input wire logic [11:0] i_slot_bank,     // Bank number per slot, 3 bits
  input wire logic i_bank_sum_ok,          // Selected bank checksum good
  input wire logic i_ram_sum_ok,           // RAM checksum good
  input wire logic i_count_wr,             // Output-on count write
  input wire logic [7:0] i_count_data,     // Output-on count value
  input wire logic i_pin_activity,         // Falling edge on serial pin
  output logic o_output_en,                // Sensor output enabled
  output logic o_load,                     // Pulse: copy bank into RAM
  output logic [2:0] o_bank,               // Bank being loaded
  output logic [7:0] o_count               // Output-on count now
);
  typedef enum logic [3:0] {
    S_WAIT = 4'b0001,
    S_LOAD = 4'b0010,
    S_RUN = 4'b0100,
    S_IDLE = 4'b1000
  } seq_t;

  seq_t state_reg;
  logic [cfg_link_pkg::TMR_W-1:0] tmr_reg;
  logic [cfg_link_pkg::TMR_W-1:0] tick_reg;
  logic [2:0] pick;

  initial begin
    if (POWERUP_CYC < 1 || TICK_CYC < 1 || IDLE_CYC < 1)
      $error("timer counts must be positive");
  end

  // Highest programmed slot wins
  always_comb begin
    pick = 3'h0;
    for (int s = 0; s < cfg_link_pkg::SLOTS; s++) begin
      if (i_slot_valid[s]) pick = i_slot_bank[3*s +: 3];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= S_WAIT;
      tmr_reg <= '0;
      o_load <= 1'b0;
      o_bank <= 3'h0;
      o_output_en <= 1'b0;
    end else begin
      o_load <= 1'b0;
      case (state_reg)
        S_WAIT: begin
          tmr_reg <= tmr_reg + 1'b1;
          if (i_instant_output_bit ||
              tmr_reg == cfg_link_pkg::TMR_W'(POWERUP_CYC - 1)) begin
            state_reg <= S_LOAD;
            o_bank <= pick;
          end
        end
        S_LOAD: begin
          o_load <= i_bank_sum_ok;
          o_output_en <= i_bank_sum_ok;
          state_reg <= S_RUN;
          tmr_reg <= '0;
        end
        S_RUN: begin
          if (i_count_wr && i_count_data != 8'h00) begin
            o_output_en <= 1'b1;
          end else if (o_output_en && o_count == 8'h00 && i_count_wr) begin
            o_output_en <= 1'b0;
          end else if (o_count == 8'h01 && tick_reg ==
                       cfg_link_pkg::TMR_W'(TICK_CYC - 1)) begin
            o_output_en <= 1'b0;
            state_reg <= S_IDLE;
            tmr_reg <= '0;
          end
        end
        S_IDLE: begin
          if (i_count_wr && i_count_data != 8'h00) begin
            o_output_en <= 1'b1;
            state_reg <= S_RUN;
          end else if (i_pin_activity) begin
            tmr_reg <= '0;
          end else if (tmr_reg == cfg_link_pkg::TMR_W'(IDLE_CYC - 1)) begin
            state_reg <= i_ram_sum_ok ? S_RUN : S_LOAD;
            o_bank <= pick;
          end else begin
            tmr_reg <= tmr_reg + 1'b1;
          end
        end
        default: state_reg <= S_WAIT;
      endcase
    end
  end

  // Output-on countdown in 10 ms steps
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_count <= cfg_link_pkg::OUT_CNT_RESET;
      tick_reg <= '0;
    end else if (i_count_wr) begin
      o_count <= i_count_data;
      tick_reg <= '0;
    end else if (o_count != 8'h00) begin
      if (tick_reg == cfg_link_pkg::TMR_W'(TICK_CYC - 1)) begin
        tick_reg <= '0;
        o_count <= o_count - 8'h01;
      end else begin
        tick_reg <= tick_reg + 1'b1;
      end
    end
  end
endmodule : power_sequencer
`default_nettype wire

//--- design/one_wire_config_link.sv
// Single-wire UART-style configuration link, top level
`timescale 1ns/1ps
`default_nettype none
module one_wire_config_link #(
  parameter int TIMEOUT_CYC = cfg_link_pkg::TIMEOUT_CYC,
  parameter int POWERUP_CYC = cfg_link_pkg::POWERUP_CYC,
  parameter int TICK_CYC = cfg_link_pkg::TICK_CYC,
  parameter int IDLE_CYC = cfg_link_pkg::IDLE_CYC,
  parameter int READ_GAP_BITS = cfg_link_pkg::READ_GAP_BITS
) (
  input wire logic I_CLK,                    // 200 MHz clock
  input wire logic I_RST,                    // Sync reset, supply invalid
  input wire logic I_SERIAL_CONFIG_PIN,      // Line level in
  output logic O_SERIAL_CONFIG_PIN,          // Line drive value, always 0
  output logic O_SERIAL_CONFIG_PIN_OE,       // High while pulling low
  input wire logic I_LINK_DISABLE_BIT,       // Link ignored when high
  input wire logic I_INSTANT_OUTPUT_BIT,     // No power-up output wait
  input wire logic I_SHARED_PIN,             // Line shared with output
  input wire logic [3:0] I_SLOT_VALID,       // Pointer slots programmed
  input wire logic [11:0] I_SLOT_BANK,       // Bank per slot
  input wire logic I_BANK_SUM_OK,            // Bank checksum good
  input wire logic I_RAM_SUM_OK,             // RAM checksum good
  input wire logic I_COUNT_WR,               // Output-on count write
  input wire logic [7:0] I_COUNT_DATA,       // Output-on count value
  input wire logic [2:0] I_RAM_SOURCE_SEL,   // Requested RAM source
  input wire logic I_RAM_SOURCE_WR,          // Source select write
  input wire logic [15:0] I_RD_DATA,         // Register read data
  output logic O_RD_REQ,                     // Pulse: read addressed reg
  output logic [6:0] O_ADDR,                 // Register address
  output logic O_WR_VALID,                   // Write word valid
  input wire logic I_WR_READY,               // Write word taken
  output logic [15:0] O_WR_DATA,             // Write word data
  output logic [6:0] O_WR_ADDR,              // Write word address
  output logic [2:0] O_RAM_SOURCE,           // Active RAM source
  output logic O_SENSOR_OUTPUT_EN,           // Sensor output enabled
  output logic O_LOAD,                       // Pulse: copy bank to RAM
  output logic [2:0] O_BANK,                 // Bank loaded
  output logic [7:0] O_OUTPUT_ON_COUNT,      // Count now
  output logic [cfg_link_pkg::BIT_W-1:0] O_BIT_CYC // Measured bit period
);
  typedef enum logic [6:0] {
    L_SYNC = 7'b0000001,
    L_MEAS = 7'b0000010,
    L_CMD = 7'b0000100,
    L_WDAT = 7'b0001000,
    L_GAP = 7'b0010000,
    L_TX = 7'b0100000,
    L_STOP = 7'b1000000
  } link_t;

  localparam int BW = cfg_link_pkg::BIT_W;
  localparam int TW = cfg_link_pkg::TMR_W;

  link_t state_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic line_reg;
  logic [BW-1:0] cnt_reg;
  logic [BW-1:0] bit_cyc_reg;
  logic [3:0] bitn_reg;
  logic [7:0] sh_reg;
  logic [3:0] edges_reg;
  logic [TW-1:0] idle_reg;
  logic rx_busy_reg;
  logic [1:0] byte_n_reg;
  logic [7:0] lo_reg;
  logic [15:0] tx_reg;
  logic tx_drive_reg;
  logic byte_done;
  logic fall;
  logic link_on;
  logic buf_ready;
  logic wr_push;
  logic [22:0] wr_word;
  logic [22:0] wr_out;
  logic [BW-1:0] cnt_tx;
  logic [BW-1:0] tx_top;

  initial begin
    if (TIMEOUT_CYC < 1 || READ_GAP_BITS < 1 || READ_GAP_BITS > 7)
      $error("timeout must be positive, read gap 1 to 7 bits");
  end

  function automatic logic [BW-1:0] half_of(input logic [BW-1:0] v);
    half_of = {1'b0, v[BW-1:1]};
  endfunction : half_of

  // Pin synchroniser
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      line_reg <= 1'b1;
    end else begin
      sync1_reg <= I_SERIAL_CONFIG_PIN;
      sync2_reg <= sync1_reg;
      line_reg <= sync2_reg;
    end
  end

  assign fall = line_reg && !sync2_reg;
  // Link works only while output is off on a shared line
  assign link_on = !I_LINK_DISABLE_BIT &&
                   !(I_SHARED_PIN && O_SENSOR_OUTPUT_EN);

  // Receiver: sample at mid-bit once a start edge is seen
  always_ff @(posedge I_CLK) begin
    if (I_RST || !link_on || state_reg == L_SYNC || state_reg == L_MEAS ||
        state_reg == L_GAP || state_reg == L_TX) begin
      rx_busy_reg <= 1'b0;
      bitn_reg <= 4'h0;
      cnt_reg <= '0;
      sh_reg <= 8'h00;
      byte_done <= 1'b0;
    end else begin
      byte_done <= 1'b0;
      if (!rx_busy_reg) begin
        if (fall) begin
          rx_busy_reg <= 1'b1;
          cnt_reg <= half_of(bit_cyc_reg);
          bitn_reg <= 4'h0;
        end
      end else if (cnt_reg == bit_cyc_reg) begin
        cnt_reg <= '0;
        bitn_reg <= bitn_reg + 4'h1;
        if (bitn_reg == 4'h0 && line_reg) begin
          rx_busy_reg <= 1'b0; // false start
        end else if (bitn_reg == 4'h9) begin
          rx_busy_reg <= 1'b0;
          byte_done <= line_reg;
        end else if (bitn_reg != 4'h0) begin
          sh_reg <= {line_reg, sh_reg[7:1]};
        end
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  // Inter-byte timeout, restarted by each byte
  always_ff @(posedge I_CLK) begin
    if (I_RST || state_reg == L_SYNC || state_reg == L_MEAS || byte_done ||
        state_reg == L_TX || state_reg == L_GAP) begin
      idle_reg <= '0;
    end else begin
      idle_reg <= idle_reg + 1'b1;
    end
  end

  // Baud measurement over the 55h byte: start edge to fifth falling edge
  // spans eight bit periods.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_reg <= L_SYNC;
      bit_cyc_reg <= '0;
      edges_reg <= 4'h0;
      O_ADDR <= 7'h00;
      O_RD_REQ <= 1'b0;
      byte_n_reg <= 2'h0;
      lo_reg <= 8'h00;
      tx_reg <= 16'h0000;
      tx_drive_reg <= 1'b0;
    end else begin
      O_RD_REQ <= 1'b0;
      if (!link_on || (state_reg != L_SYNC && state_reg != L_MEAS &&
          idle_reg == TW'(TIMEOUT_CYC - 1))) begin
        state_reg <= L_SYNC;
        tx_drive_reg <= 1'b0;
      end else begin
        case (state_reg)
          L_SYNC: begin
            edges_reg <= 4'h0;
            if (fall) begin
              state_reg <= L_MEAS;
              bit_cyc_reg <= '0;
            end
          end
          L_MEAS: begin
            bit_cyc_reg <= bit_cyc_reg + 1'b1;
            if (fall) edges_reg <= edges_reg + 4'h1;
            if (fall && edges_reg == 4'h3) begin
              // Total over 8 bits, divide by 8; wait for stop bit
              bit_cyc_reg <= BW'(bit_cyc_reg >> 3);
              state_reg <= L_CMD;
              byte_n_reg <= 2'h0;
            end else if (bit_cyc_reg ==
                         BW'(8 * cfg_link_pkg::MAX_BIT_CYC)) begin
              state_reg <= L_SYNC;
            end
          end
          L_CMD: begin
            if (byte_done) begin
              O_ADDR <= sh_reg[6:0];
              if (sh_reg[cfg_link_pkg::RW_BIT]) begin
                state_reg <= L_GAP;
                O_RD_REQ <= 1'b1;
                edges_reg <= 4'h0;
              end else begin
                state_reg <= L_WDAT;
              end
            end
          end
          L_WDAT: begin
            if (byte_done) begin
              if (byte_n_reg == 2'h0) begin
                lo_reg <= sh_reg;
                byte_n_reg <= 2'h1;
              end else begin
                byte_n_reg <= 2'h0;
                state_reg <= L_SYNC;
              end
            end
          end
          L_GAP: begin
            bit_cyc_reg <= bit_cyc_reg;
            if (edges_reg == 4'h0) tx_reg <= I_RD_DATA;
            // Half-bit steps: stop is sampled mid-bit, so one extra half
            if (cnt_tx == tx_top) begin
              edges_reg <= edges_reg + 4'h1;
              if (edges_reg == 4'(2 * READ_GAP_BITS)) begin
                state_reg <= L_TX;
                edges_reg <= 4'h0;
                byte_n_reg <= 2'h0;
              end
            end
          end
          L_TX: begin
            if (cnt_tx == bit_cyc_reg) begin
              edges_reg <= edges_reg + 4'h1;
              if (edges_reg == 4'h9) begin
                edges_reg <= 4'h0;
                if (byte_n_reg == 2'h0) begin
                  byte_n_reg <= 2'h1;
                  tx_reg <= {8'h00, tx_reg[15:8]};
                end else begin
                  state_reg <= L_SYNC;
                end
              end
            end
            // Start bit low, data LSB first, stop high
            tx_drive_reg <= (edges_reg == 4'h0) ||
                            (edges_reg != 4'h9 &&
                             !tx_reg[edges_reg[2:0] - 3'h1]);
          end
          default: state_reg <= L_SYNC;
        endcase
      end
    end
  end

  // Bit timer for gap and transmit; the gap runs in half bits
  assign tx_top = (state_reg == L_GAP) ? half_of(bit_cyc_reg) : bit_cyc_reg;
  always_ff @(posedge I_CLK) begin
    if (I_RST || (state_reg != L_GAP && state_reg != L_TX) ||
        cnt_tx == tx_top) begin
      cnt_tx <= '0;
    end else begin
      cnt_tx <= cnt_tx + 1'b1;
    end
  end

  // Open drain: only ever pulls low
  assign O_SERIAL_CONFIG_PIN = 1'b0;
  assign O_SERIAL_CONFIG_PIN_OE = tx_drive_reg && state_reg == L_TX;
  assign O_BIT_CYC = bit_cyc_reg;

  assign wr_push = state_reg == L_WDAT && byte_done && byte_n_reg == 2'h1;
  assign wr_word = {O_ADDR, sh_reg, lo_reg};

  word_buffer #(.WIDTH(23)) word_buffer_i (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_valid(wr_push),
    .o_ready(buf_ready),
    .i_data(wr_word),
    .o_valid(O_WR_VALID),
    .i_ready(I_WR_READY),
    .o_data(wr_out)
  );
  assign O_WR_ADDR = wr_out[22:16];
  assign O_WR_DATA = wr_out[15:0];

  // RAM source override over the link
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_RAM_SOURCE <= cfg_link_pkg::RAM_SRC_RESET;
    end else if (I_RAM_SOURCE_WR && !I_LINK_DISABLE_BIT) begin
      O_RAM_SOURCE <= I_RAM_SOURCE_SEL;
    end
  end

  power_sequencer #(
    .POWERUP_CYC(POWERUP_CYC),
    .TICK_CYC(TICK_CYC),
    .IDLE_CYC(IDLE_CYC)
  ) power_sequencer_i (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_instant_output_bit(I_INSTANT_OUTPUT_BIT),
    .i_slot_valid(I_SLOT_VALID),
    .i_slot_bank(I_SLOT_BANK),
    .i_bank_sum_ok(I_BANK_SUM_OK),
    .i_ram_sum_ok(I_RAM_SUM_OK),
    .i_count_wr(I_COUNT_WR),
    .i_count_data(I_COUNT_DATA),
    .i_pin_activity(fall),
    .o_output_en(O_SENSOR_OUTPUT_EN),
    .o_load(O_LOAD),
    .o_bank(O_BANK),
    .o_count(O_OUTPUT_ON_COUNT)
  );
endmodule : one_wire_config_link
`default_nettype wire

//--- tb/one_wire_config_link_monitor.sv
// Port-level assertions for the single-wire configuration link
`timescale 1ns/1ps
`default_nettype none
module one_wire_config_link_monitor #(
  parameter int POWERUP_CYC = 200
) (
  input wire logic I_CLK,                          // Clock
  input wire logic I_RST,                          // Sync reset
  input wire logic O_SERIAL_CONFIG_PIN,            // Line drive value
  input wire logic O_SERIAL_CONFIG_PIN_OE,         // Line pull enable
  input wire logic I_LINK_DISABLE_BIT,             // Link off
  input wire logic I_INSTANT_OUTPUT_BIT,           // No power-up wait
  input wire logic I_SHARED_PIN,                   // Line shared
  input wire logic I_COUNT_WR,                     // Count write
  input wire logic [2:0] I_RAM_SOURCE_SEL,         // Source request
  input wire logic I_RAM_SOURCE_WR,                // Source write
  input wire logic [2:0] O_RAM_SOURCE,             // Active source
  input wire logic O_SENSOR_OUTPUT_EN,             // Output enabled
  input wire logic [7:0] O_OUTPUT_ON_COUNT,        // Count now
  input wire logic [cfg_link_pkg::BIT_W-1:0] O_BIT_CYC // Bit period
);
  int up_cnt;
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      up_cnt <= 0;
    end else if (up_cnt < POWERUP_CYC) begin
      up_cnt <= up_cnt + 1;
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  sequence count_step;
    $changed(O_OUTPUT_ON_COUNT) && !$past(I_COUNT_WR) && !$past(I_RST);
  endsequence
  sequence bit_held;
    O_SERIAL_CONFIG_PIN_OE [*8];
  endsequence
  pin_drive_zero_a: assert property (O_SERIAL_CONFIG_PIN == 1'b0)
    else $error("line drive value not zero");
  count_step_a: assert property (count_step |->
    O_OUTPUT_ON_COUNT == $past(O_OUTPUT_ON_COUNT) - 8'h01)
    else $error("count changed by other than one");
  tick_gap_a: assert property (count_step |=>
    ($stable(O_OUTPUT_ON_COUNT) || $past(I_COUNT_WR)) [*8])
    else $error("count stepped too soon");
  count_en_a: assert property (O_OUTPUT_ON_COUNT != 8'h00 |->
    ##[0:1] O_SENSOR_OUTPUT_EN) else $error("output off with count set");
  power_hold_a: assert property (!I_INSTANT_OUTPUT_BIT &&
    up_cnt < POWERUP_CYC - 2 |-> !O_SENSOR_OUTPUT_EN)
    else $error("output on during power-up wait");
  share_block_a: assert property (I_SHARED_PIN && O_SENSOR_OUTPUT_EN
    |=> !O_SERIAL_CONFIG_PIN_OE) else $error("link drove shared line");
  disable_quiet_a: assert property (I_LINK_DISABLE_BIT |=>
    !O_SERIAL_CONFIG_PIN_OE) else $error("disabled link drove line");
  src_write_a: assert property (I_RAM_SOURCE_WR && !I_LINK_DISABLE_BIT
    |-> ##[1:2] O_RAM_SOURCE == I_RAM_SOURCE_SEL)
    else $error("source select not taken");
  reply_bit_a: assert property ($rose(O_SERIAL_CONFIG_PIN_OE) |=>
    bit_held) else $error("reply bit too short");
  rate_hold_a: assert property (O_SERIAL_CONFIG_PIN_OE |->
    $stable(O_BIT_CYC)) else $error("bit period moved in reply");
endmodule : one_wire_config_link_monitor
bind one_wire_config_link one_wire_config_link_monitor #(
  .POWERUP_CYC(POWERUP_CYC)
) mon_i (.I_CLK(I_CLK), .I_RST(I_RST),
  .O_SERIAL_CONFIG_PIN(O_SERIAL_CONFIG_PIN),
  .O_SERIAL_CONFIG_PIN_OE(O_SERIAL_CONFIG_PIN_OE),
  .I_LINK_DISABLE_BIT(I_LINK_DISABLE_BIT),
  .I_INSTANT_OUTPUT_BIT(I_INSTANT_OUTPUT_BIT), .I_SHARED_PIN(I_SHARED_PIN),
  .I_COUNT_WR(I_COUNT_WR), .I_RAM_SOURCE_SEL(I_RAM_SOURCE_SEL),
  .I_RAM_SOURCE_WR(I_RAM_SOURCE_WR), .O_RAM_SOURCE(O_RAM_SOURCE),
  .O_SENSOR_OUTPUT_EN(O_SENSOR_OUTPUT_EN),
  .O_OUTPUT_ON_COUNT(O_OUTPUT_ON_COUNT), .O_BIT_CYC(O_BIT_CYC));
`default_nettype wire

//--- tb/wire_controller_model.sv
// Calibration controller model on the open-drain configuration line
`timescale 1ns/1ps
`default_nettype none
module wire_controller_model (
  input wire logic i_clk,  // Clock
  input wire logic i_line, // Resolved line level
  output logic o_pull_low  // High pulls the line low
);
  initial o_pull_low = 1'b0;
  task automatic send_byte(input logic [7:0] data, input int period);
    logic [9:0] frame;
    frame = {1'b1, data, 1'b0};
    for (int b = 0; b < 10; b++) begin
      @(posedge i_clk);
      o_pull_low <= ~frame[b];
      repeat (period - 1) @(posedge i_clk);
    end
  endtask : send_byte
  // Gap counts clocks from entry to the reply's start bit
  task automatic recv_byte(input int period, output logic [7:0] data,
                           output int gap);
    gap = 0;
    while (i_line !== 1'b0 && gap < 8 * period) begin
      @(posedge i_clk);
      gap++;
    end
    repeat (period / 2) @(posedge i_clk);
    for (int b = 0; b < 8; b++) begin
      repeat (period) @(posedge i_clk);
      data[b] = i_line;
    end
    repeat (period) @(posedge i_clk);
  endtask : recv_byte
endmodule : wire_controller_model
`default_nettype wire

//--- tb/one_wire_config_link_tb_top.sv
// Self-checking bench for the single-wire configuration link
`timescale 1ns/1ps
`default_nettype none
module one_wire_config_link_tb_top;
  localparam int P_CYC = 200;
  localparam int T_CYC = 50;
  localparam int I_CYC = 300;
  localparam int TO_CYC = 24000;
  localparam int BIT_A = 1760;
  localparam int BIT_B = 1800;
  localparam int LIMIT = 300000;
  logic clk, rst, dis, inst, shared, bsum, rsum, cwr, swr, wready;
  logic pin_o, pin_oe, rd_req, wvalid, en, load, ctl_low, line;
  logic [7:0] cdata, count;
  logic [2:0] src_sel, src, bank;
  logic [15:0] rd_data, wdata;
  logic [6:0] addr, waddr;
  logic [cfg_link_pkg::BIT_W-1:0] bit_cyc;
  int err_count, total_checks, cyc;
  assign line = ((pin_oe && !pin_o) || ctl_low) ? 1'b0 : 1'b1;
  one_wire_config_link #(.TIMEOUT_CYC(TO_CYC), .POWERUP_CYC(P_CYC),
    .TICK_CYC(T_CYC), .IDLE_CYC(I_CYC)) one_wire_config_link_i (
    .I_CLK(clk), .I_RST(rst), .I_SERIAL_CONFIG_PIN(line),
    .O_SERIAL_CONFIG_PIN(pin_o), .O_SERIAL_CONFIG_PIN_OE(pin_oe),
    .I_LINK_DISABLE_BIT(dis), .I_INSTANT_OUTPUT_BIT(inst),
    .I_SHARED_PIN(shared), .I_SLOT_VALID(4'h7),
    .I_SLOT_BANK(12'h6A1), .I_BANK_SUM_OK(bsum), .I_RAM_SUM_OK(rsum),
    .I_COUNT_WR(cwr), .I_COUNT_DATA(cdata), .I_RAM_SOURCE_SEL(src_sel),
    .I_RAM_SOURCE_WR(swr), .I_RD_DATA(rd_data), .O_RD_REQ(rd_req),
    .O_ADDR(addr), .O_WR_VALID(wvalid), .I_WR_READY(wready),
    .O_WR_DATA(wdata), .O_WR_ADDR(waddr), .O_RAM_SOURCE(src),
    .O_SENSOR_OUTPUT_EN(en), .O_LOAD(load), .O_BANK(bank),
    .O_OUTPUT_ON_COUNT(count), .O_BIT_CYC(bit_cyc));
  wire_controller_model ctl_i (.i_clk(clk), .i_line(line), .o_pull_low(ctl_low));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check_eq(input string what, input logic [19:0] exp,
                          input logic [19:0] seen);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_eq
  task automatic check_in(input string what, input int lo, input int hi,
                          input logic [19:0] seen);
    total_checks++;
    if ((seen >= lo && seen <= hi) !== 1'b1) begin
      err_count++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask : check_in
  task automatic wait_lvl(ref logic sig, input logic lvl, input int lim,
                          output int n);
    n = 0;
    while (sig !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) check_eq("wait bound", 20'h0_0001, 20'h0_0000);
  endtask : wait_lvl
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin : main
    int n;
    int g;
    logic [7:0] b0, b1;
    {rst, bsum, rsum} = 3'h7;
    {dis, inst, shared, cwr, swr, wready} = 6'h00;
    {cdata, src_sel, rd_data, err_count, total_checks, cyc} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_lvl(load, 1'b1, P_CYC + 50, n);
    check_in("power-up wait", P_CYC - 2, P_CYC + 50, n);
    check_eq("loaded bank", 20'h0_0002, bank);
    wait_lvl(en, 1'b1, 10, n);
    shared <= 1'b1;
    dis <= 1'b1;
    repeat (4) @(posedge clk);
    check_eq("line pull while shared", 20'h0_0000, pin_oe);
    {shared, dis} <= 2'h0;
    $display("test power-up done");
    cdata <= 8'h03;
    cwr <= 1'b1;
    @(posedge clk);
    cwr <= 1'b0;
    wait_lvl(en, 1'b0, 4 * T_CYC, n);
    check_in("output on time", 2 * T_CYC, 3 * T_CYC + 4, n);
    rsum <= 1'b0;
    wait_lvl(load, 1'b1, I_CYC + 50, n);
    check_in("idle reload", I_CYC - 4, I_CYC + 50, n);
    rsum <= 1'b1;
    src_sel <= 3'h4;
    swr <= 1'b1;
    @(posedge clk);
    swr <= 1'b0;
    repeat (3) @(posedge clk);
    check_eq("ram source", 20'h0_0004, src);
    $display("test output timer done");
    ctl_i.send_byte(8'h55, BIT_A);
    repeat (TO_CYC + 1000) @(posedge clk);
    ctl_i.send_byte(8'h55, BIT_A);
    ctl_i.send_byte(8'h12, BIT_A);
    ctl_i.send_byte(8'hCD, BIT_A);
    ctl_i.send_byte(8'hAB, BIT_A);
    wait_lvl(wvalid, 1'b1, 4 * BIT_A, n);
    check_eq("write word", 20'h0_ABCD, wdata);
    check_eq("write addr", 20'h0_0012, waddr);
    check_in("bit period a", BIT_A - 8, BIT_A + 8, bit_cyc);
    repeat (20) @(posedge clk);
    check_eq("stalled word", 20'h0_ABCD, wdata);
    wready <= 1'b1;
    @(posedge clk);
    wready <= 1'b0;
    @(posedge clk);
    check_eq("drained valid", 20'h0_0000, wvalid);
    $display("test write done");
    rd_data <= 16'h3C5A;
    ctl_i.send_byte(8'h55, BIT_B);
    ctl_i.send_byte(8'hA1, BIT_B);
    check_eq("read addr", 20'h0_0021, addr);
    check_in("bit period b", BIT_B - 8, BIT_B + 8, bit_cyc);
    ctl_i.recv_byte(BIT_B, b0, g);
    check_in("reply gap", BIT_B * 2 - 20, BIT_B * 2 + 20, g);
    ctl_i.recv_byte(BIT_B, b1, g);
    check_eq("reply low byte", 20'h0_005A, b0);
    check_eq("reply high byte", 20'h0_003C, b1);
    $display("test read done");
    report_and_stop();
  end
endmodule : one_wire_config_link_tb_top
`default_nettype wire
